/* File: rtl/scp_pkg.sv */
package scp_pkg;
  localparam int FRAME_BITS = 16;
  localparam int NUM_REGS = 16;
  localparam int REG_W = 9;
  localparam int NUM_CH = 8;
  localparam int CODE_W = 12;
  // control register offsets
  localparam logic [3:0] OFS_NO_OP = 4'h0;
  localparam logic [3:0] OFS_DAC_RB = 4'h1;
  localparam logic [3:0] OFS_SEQ = 4'h2;
  localparam logic [3:0] OFS_GEN_CTRL = 4'h3;
  localparam logic [3:0] OFS_AIN_SEL = 4'h4;
  localparam logic [3:0] OFS_AOUT_SEL = 4'h5;
  localparam logic [3:0] OFS_PULLDOWN = 4'h6;
  localparam logic [3:0] OFS_RB_LOAD = 4'h7;
  localparam logic [3:0] OFS_DOUT_SEL = 4'h8;
  localparam logic [3:0] OFS_DOUT_LVL = 4'h9;
  localparam logic [3:0] OFS_DIN_SEL = 4'hA;
  localparam logic [3:0] OFS_PWR_REF = 4'hB;
  localparam logic [3:0] OFS_DRIVE = 4'hC;
  localparam logic [3:0] OFS_HIZ = 4'hD;
  localparam logic [3:0] OFS_RSVD = 4'hE;
  localparam logic [3:0] OFS_SOFT_RST = 4'hF;
  // reset values
  localparam logic [8:0] RST_PULLDOWN = 9'h0FF;
  localparam logic [8:0] RST_OTHER = 9'h000;
  localparam logic [11:0] RST_CODE = 12'h000;
  localparam logic [10:0] SOFT_RST_KEY = 11'h5AC;
  // field positions
  localparam int LOCK_BIT = 7;
  localparam int RB_EN_BIT = 6;
  localparam int RB_ADDR_LSB = 2;
  localparam int DAC_RB_EN_BIT = 3;
  localparam int BUSY_PIN_BIT = 8;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int CONFIG_TIME_US = 250;
  localparam int CONFIG_CYCLES = CONFIG_TIME_US * CLK_MHZ;

  // incoming frame as laid out on the wire
  typedef struct packed {
    logic is_code;
    logic [3:0] addr;
    logic [1:0] zero;
    logic [8:0] data;
  } scp_frame_t;

  // conversion result from the converter logic
  typedef struct packed {
    logic [2:0] chan;
    logic [11:0] code;
  } scp_result_t;
endpackage

/* File: rtl/scp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module scp_port #(
  parameter int unsigned CONFIG_CYCLES = scp_pkg::CONFIG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_serial_data_in,
  output logic o_serial_data_out,
  input wire logic i_conv_valid,
  input wire scp_pkg::scp_result_t i_conv_result,
  output logic o_conv_req,
  output logic [2:0] o_conv_chan,
  output logic o_config_busy,
  output logic o_pin7_busy,
  output logic [15:0][8:0] o_regs,
  output logic [7:0][11:0] o_dac_codes
);
  localparam int CW = $clog2(CONFIG_CYCLES + 1);

  // ---------------- link domain (serial clock) ----------------
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [15:0] hold_reg, hold_next;
  logic full_reg, full_next;
  logic dout_reg, dout_next;
  logic [15:0] tx_reg;

  // shift path; counter saturates so extra bits are ignored
  always_comb
  begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    hold_next = hold_reg;
    full_next = full_reg;
    if (bit_cnt_reg < 5'h10)
    begin
      shift_next = {shift_reg[14:0], i_serial_data_in};
      bit_cnt_next = bit_cnt_reg + 5'h01;
    end
    if (bit_cnt_reg == 5'h0F)
    begin
      hold_next = {shift_reg[14:0], i_serial_data_in};
      full_next = 1'b1;
    end
  end

  // sample on falling edge; frame select high drops partial frames
  always_ff @(negedge i_sclk or posedge i_sync_n)
  begin
    if (i_sync_n)
    begin
      bit_cnt_reg <= 5'h00;
      full_reg <= 1'b0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_next;
      full_reg <= full_next;
    end
  end

  // data flops need no reset: only read once full is seen
  always_ff @(negedge i_sclk)
  begin
    shift_reg <= shift_next;
    hold_reg <= hold_next;
  end

  // answer bit; tx_reg is quiet during a frame so it is read as static
  always_comb
  begin
    dout_next = 1'b0;
    if (bit_cnt_reg < 5'h10)
      dout_next = tx_reg[4'(15 - bit_cnt_reg[3:0])];
  end

  // output moves on rising edge; idles low between frames
  always_ff @(posedge i_sclk or posedge i_sync_n)
  begin
    if (i_sync_n)
      dout_reg <= 1'b0;
    else
      dout_reg <= dout_next;
  end

  assign o_serial_data_out = dout_reg;

  // ---------------- system domain ----------------
  logic sync_meta_reg, sync_s2_reg, sync_s3_reg;
  logic full_meta_reg, full_s2_reg;

  // two-flop synchronisers for frame select and frame-full level
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sync_meta_reg <= 1'b1;
      sync_s2_reg <= 1'b1;
      sync_s3_reg <= 1'b1;
      full_meta_reg <= 1'b0;
      full_s2_reg <= 1'b0;
    end
    else
    begin
      sync_meta_reg <= i_sync_n;
      sync_s2_reg <= sync_meta_reg;
      sync_s3_reg <= sync_s2_reg;
      full_meta_reg <= full_reg;
      full_s2_reg <= full_meta_reg;
    end
  end

  logic [8:0] regs_reg [16];
  logic [8:0] regs_next [16];
  logic [11:0] code_reg [8];
  logic [11:0] code_next [8];
  logic [15:0] tx_next;
  logic got_reg, got_next;
  logic [CW-1:0] cfg_cnt_reg, cfg_cnt_next;
  logic busy_reg, busy_next;
  logic req_reg, req_next;
  logic [2:0] chan_reg, chan_next;
  logic [2:0] last_reg, last_next;
  logic pin7_reg, pin7_next;

  // pin function registers that exclude each other
  function automatic logic is_func(input logic [3:0] a);
    is_func = (a == scp_pkg::OFS_AIN_SEL) || (a == scp_pkg::OFS_AOUT_SEL) ||
              (a == scp_pkg::OFS_PULLDOWN) || (a == scp_pkg::OFS_DOUT_SEL) ||
              (a == scp_pkg::OFS_DIN_SEL) || (a == scp_pkg::OFS_HIZ);
  endfunction

  // analog in with out, and digital in with out, may share a pin
  function automatic logic may_share(input logic [3:0] a, input logic [3:0] b);
    may_share = ((a == scp_pkg::OFS_AIN_SEL) && (b == scp_pkg::OFS_AOUT_SEL)) ||
                ((a == scp_pkg::OFS_AOUT_SEL) && (b == scp_pkg::OFS_AIN_SEL)) ||
                ((a == scp_pkg::OFS_DOUT_SEL) && (b == scp_pkg::OFS_DIN_SEL)) ||
                ((a == scp_pkg::OFS_DIN_SEL) && (b == scp_pkg::OFS_DOUT_SEL));
  endfunction

  scp_pkg::scp_frame_t frm;
  logic exec, frame_start, do_reset;
  logic [2:0] cand;

  assign frm = scp_pkg::scp_frame_t'(hold_reg);
  // execute on frame select rising after a full frame
  assign exec = sync_s2_reg && !sync_s3_reg && (got_reg || full_s2_reg) && !busy_reg;
  assign frame_start = !sync_s2_reg && sync_s3_reg;
  // key written to the reset register
  assign do_reset = exec && !frm.is_code && (frm.addr == scp_pkg::OFS_SOFT_RST) &&
                    ({frm.zero, frm.data} == scp_pkg::SOFT_RST_KEY);

  // command decode, register file and answer word
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      regs_next[i] = regs_reg[i];
    for (int i = 0; i < 8; i++)
      code_next[i] = code_reg[i];
    tx_next = tx_reg;
    got_next = got_reg;
    cfg_cnt_next = cfg_cnt_reg;
    busy_next = busy_reg;
    req_next = 1'b0;
    chan_next = chan_reg;
    last_next = last_reg;
    cand = 3'h0;
    if (full_s2_reg && !sync_s2_reg)
      got_next = 1'b1;
    if (sync_s2_reg && !sync_s3_reg)
      got_next = 1'b0;
    if (busy_reg)
    begin
      if (cfg_cnt_reg <= CW'(1))
        busy_next = 1'b0;
      else
        cfg_cnt_next = cfg_cnt_reg - CW'(1);
    end
    // start next sequenced conversion at each frame start once configuration is over
    if (frame_start && !busy_reg && (regs_reg[scp_pkg::OFS_SEQ][7:0] != 8'h00))
    begin
      for (int k = 8; k >= 1; k--)
      begin
        cand = 3'(last_reg + 3'(k));
        if (regs_reg[scp_pkg::OFS_SEQ][cand])
          chan_next = cand;
      end
      last_next = chan_next;
      req_next = 1'b1;
    end
    if (i_conv_valid)
      tx_next = {1'b0, i_conv_result.chan, i_conv_result.code};
    if (exec)
    begin
      if (frm.is_code)
      begin
        if (regs_reg[scp_pkg::OFS_AOUT_SEL][frm.addr[3:1]])
          code_next[frm.addr[3:1]] = {frm.addr[0], frm.zero, frm.data};
      end
      else if (is_func(frm.addr))
      begin
        // lock bit freezes pin functions; last write wins on conflicts
        if (!regs_reg[scp_pkg::OFS_GEN_CTRL][scp_pkg::LOCK_BIT])
        begin
          // pin function selects
          // bit8 kept only where it assigns the busy pin
          if (frm.addr == scp_pkg::OFS_DOUT_SEL)
            regs_next[frm.addr] = frm.data;
          else
            regs_next[frm.addr] = {1'b0, frm.data[7:0]};
          for (int r = 0; r < 16; r++)
            if (is_func(4'(r)) && (4'(r) != frm.addr) && !may_share(frm.addr, 4'(r)))
              regs_next[r] = regs_reg[r] & ~{1'b0, frm.data[7:0]};
        end
      end
      else if ((frm.addr != scp_pkg::OFS_NO_OP) && (frm.addr != scp_pkg::OFS_RSVD) &&
               (frm.addr != scp_pkg::OFS_SOFT_RST))
      begin
        // low nine bits are the value
        regs_next[frm.addr] = frm.data;
        if ((frm.addr == scp_pkg::OFS_RB_LOAD) && frm.data[scp_pkg::RB_EN_BIT])
          tx_next = {1'b0, frm.data[scp_pkg::RB_ADDR_LSB +: 4], 2'b00,
                     regs_reg[frm.data[scp_pkg::RB_ADDR_LSB +: 4]]};
        if ((frm.addr == scp_pkg::OFS_DAC_RB) && frm.data[scp_pkg::DAC_RB_EN_BIT])
          tx_next = {1'b0, frm.data[2:0], code_reg[frm.data[2:0]]};
      end
    end
    // software reset reloads defaults and reruns configuration
    if (do_reset)
    begin
      for (int i = 0; i < 16; i++)
        regs_next[i] = scp_pkg::RST_OTHER;
      regs_next[scp_pkg::OFS_PULLDOWN] = scp_pkg::RST_PULLDOWN;
      for (int i = 0; i < 8; i++)
        code_next[i] = scp_pkg::RST_CODE;
      tx_next = 16'h0000;
      busy_next = 1'b1;
      cfg_cnt_next = CW'(CONFIG_CYCLES);
      last_next = 3'h7;
    end
  end

  // pin seven busy flag follows bit8 of the digital output select
  assign pin7_next = regs_next[scp_pkg::OFS_DOUT_SEL][scp_pkg::BUSY_PIN_BIT];

  // register stage for the system domain
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < 16; i++)
        regs_reg[i] <= scp_pkg::RST_OTHER;
      regs_reg[scp_pkg::OFS_PULLDOWN] <= scp_pkg::RST_PULLDOWN;
      for (int i = 0; i < 8; i++)
        code_reg[i] <= scp_pkg::RST_CODE;
      tx_reg <= 16'h0000;
      got_reg <= 1'b0;
      busy_reg <= 1'b1;
      cfg_cnt_reg <= CW'(CONFIG_CYCLES);
      req_reg <= 1'b0;
      chan_reg <= 3'h0;
      last_reg <= 3'h7;
      pin7_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
        regs_reg[i] <= regs_next[i];
      for (int i = 0; i < 8; i++)
        code_reg[i] <= code_next[i];
      tx_reg <= tx_next;
      got_reg <= got_next;
      busy_reg <= busy_next;
      cfg_cnt_reg <= cfg_cnt_next;
      req_reg <= req_next;
      chan_reg <= chan_next;
      last_reg <= last_next;
      pin7_reg <= pin7_next;
    end
  end

  // outputs straight from flops
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      o_regs[i] = regs_reg[i];
    for (int i = 0; i < 8; i++)
      o_dac_codes[i] = code_reg[i];
  end
  assign o_conv_req = req_reg;
  assign o_conv_chan = chan_reg;
  assign o_config_busy = busy_reg;
  assign o_pin7_busy = pin7_reg;
endmodule
`default_nettype wire

/* File: sim/scp_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module scp_port_checker #(
  parameter int unsigned CONFIG_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sync_n,
  input wire logic o_serial_data_out,
  input wire logic o_conv_req,
  input wire logic [2:0] o_conv_chan,
  input wire logic o_config_busy,
  input wire logic [15:0][8:0] o_regs,
  input wire logic [7:0][11:0] o_dac_codes
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  // length of the current busy stretch
  always_comb
  begin
    busy_cnt_next = o_config_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge i_clk)
  begin
    busy_cnt_reg <= i_srst ? 16'h0000 : busy_cnt_next;
  end
  // long low stretch: any execution of the last frame is long over
  sequence s_low_run;
    (!i_sync_n) [*6];
  endsequence
  sequence s_busy_run;
    o_config_busy [*3];
  endsequence
  chk_reset_vals: assert property (disable iff (1'b0) i_srst |=>
    o_regs[6] == 9'h0FF && o_regs[5] == 9'h000 && o_dac_codes == '0 && o_config_busy)
    else $error("reset values wrong");
  chk_busy_len: assert property ($fell(o_config_busy) |->
    busy_cnt_reg >= CONFIG_CYCLES - 1 && busy_cnt_reg <= CONFIG_CYCLES + 2)
    else $error("busy period length wrong");
  chk_conv_pulse: assert property (o_conv_req |=> !o_conv_req)
    else $error("conversion request longer than one cycle");
  chk_conv_chan: assert property (o_conv_req |-> o_regs[2][o_conv_chan])
    else $error("conversion of an unselected channel");
  chk_regs_quiet: assert property (s_low_run |=>
    $stable(o_regs) && $stable(o_dac_codes))
    else $error("registers changed in mid frame");
  chk_busy_hold: assert property (s_busy_run |=> $stable(o_dac_codes))
    else $error("code written while busy");
  chk_sdo_idle: assert property (i_sync_n [*2] |-> !o_serial_data_out)
    else $error("serial output driven outside frame");
  chk_rsvd_zero: assert property (
    o_regs[0] == 9'h000 && o_regs[14] == 9'h000 && o_regs[15] == 9'h000)
    else $error("reserved slot holds data");
endmodule
bind scp_port scp_port_checker #(.CONFIG_CYCLES(CONFIG_CYCLES)) u_chk (.i_clk, .i_srst,
  .i_sync_n, .o_serial_data_out, .o_conv_req, .o_conv_chan, .o_config_busy, .o_regs,
  .o_dac_codes);
`default_nettype wire

/* File: sim/scp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scp_host (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_data_to_dev,
  input wire logic i_data_from_dev
);
  // clock idles high and stands still between frames
  // short low pulse gives the link flops a clean clearing edge at start
  initial
  begin
    o_sclk = 1'b1;
    o_sync_n = 1'b0;
    o_data_to_dev = 1'b0;
    #5 o_sync_n = 1'b1;
  end
  // one frame, msb first; output sampled just before each fall
  task automatic xfer(input logic [15:0] w, input int nbits, input bit rd,
                      output logic [15:0] q);
    int hp;
    // slower clock when the answer is read
    hp = rd ? 26 : 16;
    q = 16'h0000;
    // frame select low opens the frame
    o_sync_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      o_data_to_dev = w[15 - i];
      #(hp);
      q[15 - i] = i_data_from_dev;
      o_sclk = 1'b0;
      #(hp);
      o_sclk = 1'b1;
    end
    // released data line shows the inverse, not a stale bit
    o_data_to_dev = ~o_data_to_dev;
    // close the frame and keep select high for the gap
    #30 o_sync_n = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

/* File: sim/scp_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module scp_port_tb;
  logic i_clk, i_srst, sclk, sync_n, din, dout, conv_valid, conv_req, cfg_busy, pin7;
  scp_pkg::scp_result_t conv_result;
  logic [2:0] conv_chan;
  logic [15:0][8:0] regs;
  logic [7:0][11:0] codes;
  logic [15:0] q;
  int miscompares = 0;
  int num_checks = 0;
  int n_req = 0;
  // conversion request pulses, counted on the system clock
  always @(posedge i_clk)
    if (conv_req === 1'b1)
      n_req++;
  scp_port #(.CONFIG_CYCLES(20)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk),
    .i_sync_n(sync_n), .i_serial_data_in(din), .o_serial_data_out(dout),
    .i_conv_valid(conv_valid), .i_conv_result(conv_result), .o_conv_req(conv_req),
    .o_conv_chan(conv_chan), .o_config_busy(cfg_busy), .o_pin7_busy(pin7),
    .o_regs(regs), .o_dac_codes(codes));
  scp_host host (.o_sclk(sclk), .o_sync_n(sync_n), .o_data_to_dev(din),
    .i_data_from_dev(dout));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // control frame with the two spare bits zero
  function automatic logic [15:0] ctl(input logic [3:0] a, input logic [8:0] d);
    return {1'b0, a, 2'b00, d};
  endfunction
  task automatic wr(input logic [15:0] w);
    host.xfer(w, 16, 1'b0, q);
  endtask
  // no frame until the configuration period is over
  task automatic wait_idle();
    int n;
    n = 0;
    while (cfg_busy !== 1'b0 && n < 200)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 200)
    begin
      miscompares++;
      results();
    end
    // next frame starts off the clock edge
    #1;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 16; i++)
      check("reg", 16'(regs[i]), (i == 6) ? 16'h00FF : 16'h0000);
    check("codes", 16'(codes[0] | codes[7]), 16'h0000);
    check("busy", 16'(cfg_busy), 16'h0001);
  endtask
  task automatic t_regs();
    logic [3:0] a [6] = '{4'h1, 4'h3, 4'h7, 4'h9, 4'hB, 4'hC};
    foreach (a[i])
    begin
      wr(ctl(a[i], 9'h055 ^ 9'(a[i])));
      check("reg", 16'(regs[a[i]]), 16'h0055 ^ 16'(a[i]));
    end
    wr(ctl(4'h5, 9'h004));
    check("aout", 16'(regs[5]), 16'h0004);
    check("pulldown", 16'(regs[6]), 16'h00FB);
    wr(ctl(4'h8, 9'h100));
    check("busy pin", 16'(pin7), 16'h0001);
  endtask
  // no-op and a frame cut short both leave state alone
  task automatic t_drop();
    wr(ctl(4'h0, 9'h1FF));
    check("nop", 16'(regs[9]), 16'h005C);
    host.xfer(ctl(4'h9, 9'h1FF), 10, 1'b0, q);
    check("partial", 16'(regs[9]), 16'h005C);
    wr(ctl(4'hE, 9'h1FF));
    check("reserved", 16'(regs[14]), 16'h0000);
  endtask
  task automatic t_code();
    wr({1'b1, 3'h2, 12'hABC});
    check("code2", 16'(codes[2]), 16'h0ABC);
    wr({1'b1, 3'h3, 12'h777});
    check("code3", 16'(codes[3]), 16'h0000);
  endtask
  task automatic t_read();
    wr(ctl(4'h7, 9'h064));
    host.xfer(ctl(4'h0, 9'h000), 16, 1'b1, q);
    check("reg read", q, 16'h485C);
    wr(ctl(4'h1, 9'h00A));
    host.xfer(ctl(4'h0, 9'h000), 16, 1'b1, q);
    check("code read", q, 16'h2ABC);
  endtask
  task automatic t_conv();
    @(posedge i_clk);
    #1 conv_valid = 1'b1;
    conv_result = '{chan: 3'h5, code: 12'h123};
    @(posedge i_clk);
    #1 conv_valid = 1'b0;
    host.xfer(ctl(4'h0, 9'h000), 16, 1'b1, q);
    check("result", q, 16'h5123);
    wr(ctl(4'h2, 9'h00C));
    wr(ctl(4'h0, 9'h000));
    check("conv chan", 16'(conv_chan[2:1]), 16'h0001);
    check("conv req", 16'(n_req), 16'h0001);
    wr(ctl(4'h0, 9'h000));
    check("conv next", 16'(conv_chan), 16'h0003);
    check("conv req2", 16'(n_req), 16'h0002);
  endtask
  task automatic t_soft();
    wr(ctl(4'hF, 9'h1AC));
    check("no reset", 16'(regs[9]), 16'h005C);
    wr({1'b0, 4'hF, 11'h5AC});
    check("busy", 16'(cfg_busy), 16'h0001);
    check("pulldown", 16'(regs[6]), 16'h00FF);
    check("code", 16'(codes[2]), 16'h0000);
    wait_idle();
  endtask
  initial
  begin
    i_srst = 1'b1;
    conv_valid = 1'b0;
    conv_result = '0;
    repeat (20) @(posedge i_clk);
    #1 i_srst = 1'b0;
    t_reset();
    wait_idle();
    t_regs();
    t_drop();
    t_code();
    t_read();
    t_conv();
    t_soft();
    results();
  end
endmodule
`default_nettype wire
